// >>> core/aacr_core.sv
/*
 * Control and status core of a speaker plus headphone audio block:
 * two-wire slave on the link clock, register bank and output decode
 * on the system clock, toggle handshakes between the two.
 * Assumes scl_i and sda_i come straight from pins, the link clock is
 * several times faster than SCL, and fault inputs are async levels.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] Headphone register bits 7..5 ignore writes
// [RULE2] Bits 4..2 of register 7 set limit
// [RULE3] Limit codes map to fixed swing levels
// [RULE4] Bits 1..0 set headphone gain, reset zero
// [RULE5] Gain codes: +6, 0, -6, -14 dB
// [RULE6] Register 3 bits 2..0 choose mux source
// [RULE7] Mux mode resets to first stereo pair
// [RULE8] Codes 0..2: mono, pair one, pair two
// [RULE9] Code 3 differential pairs, 4 summed differences
// [RULE10] Codes 5,6 sum a pair; 7 mutes
// [RULE11] Differential mode uses pair one volume
// [RULE12] Mixing acts after per-input volume
// [RULE13] Start-up with soft shutdown bit set
// [RULE14] Shutdown disables all but serial interface
// [RULE15] Enable bits 3..1 switch amplifiers on
// [RULE16] One bit enables both speaker channels
// [RULE17] Headphone left and right enable separately
// [RULE18] Speaker over-current flags latch, clear-on-zero
// [RULE19] Headphone over-current flags latch, clear-on-zero
// [RULE20] Thermal flag follows shutdown state live
// [RULE21] Reset low blocks all writes
// [RULE22] Reset restores every register default
// [RULE23] Lock rejects limit and lock writes
// [RULE24] Lock clears only through reset
// [RULE25] Other fields stay writable while locked
// [RULE26] Writes commit after data byte acknowledge
module aacr_core (
    input  wire logic                sys_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                link_clk_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_o,
    input  wire logic                spk_l_oc_i,
    input  wire logic                spk_r_oc_i,
    input  wire logic                hp_l_oc_i,
    input  wire logic                hp_r_oc_i,
    input  wire logic                thermal_i,
    output logic                     bias_on_o,
    output logic                     spk_on_o,
    output logic                     hp_l_on_o,
    output logic                     hp_r_on_o,
    output logic [9:0]               left_mix_o,
    output logic [9:0]               right_mix_o,
    output logic [4:0]               mono_gain_o,
    output logic [4:0]               st1_gain_o,
    output logic [4:0]               st2_gain_o,
    output logic [1:0]               headphone_gain_select_sel_o,
    output logic signed [4:0]        headphone_gain_select_db_o,
    output logic [2:0]               hp_limit_code_o,
    output logic [10:0]              hp_limit_mv_o,
    output logic                     limit_lock_o
);
    import aacr_pkg::*;

    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_AACK, L_PTR, L_PACK,
        L_WDATA, L_WACK, L_RDATA, L_RACK
    } aacr_lstate_t;

    // Link domain state
    logic              lrst_s1_r, lrst_n_r;
    logic [1:0]        pin_s1_r, pin_s2_r, pin_s3_r;
    logic              ack_s1_r, ack_s2_r, ack_s3_r;
    aacr_lstate_t      lstate_r;
    logic [3:0]        cnt_r;
    logic [7:0]        shreg_r, ptr_r, rd_buf_r;
    logic              rw_r, nack_r, sda_oe_r;
    logic [7:0]        wr_addr_r, wr_data_r, rd_addr_r;
    logic              wr_tog_r, rd_tog_r;
    logic              scl_rise, scl_fall, start_c, stop_c;

    // System domain state
    logic              wt_s1_r, wt_s2_r, wt_s3_r;
    logic              rt_s1_r, rt_s2_r, rt_s3_r;
    logic [4:0]        evt_s1_r, evt_s2_r;
    logic [7:0]        rd_data_r, rd_mux;
    logic              rd_ack_tog_r, wr_fire;
    logic [3:0]        flt_r, power_r;
    logic              lock_r;
    logic [2:0]        mode_r, vlim_r;
    logic [4:0]        mono_r, st1_r, st2_r;
    logic [1:0]        hpg_r;

    // Mix coefficients {left, right}; each five inputs of two bits:
    // mono, left1, right1, left2, right2. They weight post-volume signals.
    function automatic logic [19:0] mix_of(input logic [2:0] m);
        logic [1:0] a, s, o;
        a = AACR_MIX_ADD;
        s = AACR_MIX_SUB;
        o = AACR_MIX_OFF;
        unique case (aacr_mode_t'(m))
            AACR_MONO_DIFF:   mix_of = {a, o, o, o, o, a, o, o, o, o};
            AACR_STEREO1:     mix_of = {o, a, o, o, o, o, o, a, o, o};
            AACR_STEREO2:     mix_of = {o, o, o, a, o, o, o, o, o, a};
            AACR_STEREO_DIFF: mix_of = {o, a, s, o, o, o, o, o, a, s};
            AACR_DIFF_MONO:   mix_of = {o, a, s, a, s, o, a, s, a, s};
            AACR_ST1_MONO:    mix_of = {o, a, a, o, o, o, a, a, o, o};
            AACR_ST2_MONO:    mix_of = {o, o, o, a, a, o, o, o, a, a};
            AACR_MUTE:        mix_of = {o, o, o, o, o, o, o, o, o, o};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link clock domain

    // Reset into the link domain; pin and toggle synchronisers
    always_ff @(posedge link_clk_i) begin
        lrst_s1_r <= reset_n_i;
        lrst_n_r  <= lrst_s1_r;
        pin_s1_r  <= {scl_i, sda_i};
        pin_s2_r  <= pin_s1_r;
        pin_s3_r  <= pin_s2_r;
        ack_s1_r  <= rd_ack_tog_r;
        ack_s2_r  <= ack_s1_r;
        ack_s3_r  <= ack_s2_r;
    end

    // Bus events from the second and third stages only
    assign scl_rise = pin_s2_r[1] & ~pin_s3_r[1];
    assign scl_fall = ~pin_s2_r[1] & pin_s3_r[1];
    assign start_c  = pin_s2_r[1] & pin_s3_r[1]
                      & ~pin_s2_r[0] & pin_s3_r[0];
    assign stop_c   = pin_s2_r[1] & pin_s3_r[1]
                      & pin_s2_r[0] & ~pin_s3_r[0];

    // Read answer word is stable once its toggle is seen
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_r) begin
            rd_buf_r <= 8'h00;
        end else if (ack_s2_r ^ ack_s3_r) begin
            rd_buf_r <= rd_data_r;
        end
    end

    // Two-wire slave: sample on SCL rise, change SDA on SCL fall
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_r) begin
            lstate_r  <= L_IDLE;
            cnt_r     <= 4'h0;
            shreg_r   <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe_r  <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            wr_tog_r  <= 1'b0;
            rd_addr_r <= 8'h00;
            rd_tog_r  <= 1'b0;
        end else if (start_c) begin
            lstate_r <= L_ADDR;
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_c) begin
            lstate_r <= L_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (lstate_r)
                L_IDLE: begin
                end
                L_ADDR, L_PTR, L_WDATA: begin
                    if (scl_rise) begin
                        shreg_r <= {shreg_r[6:0], pin_s2_r[0]};
                        cnt_r   <= 4'(cnt_r + 4'h1);
                    end else if (scl_fall && cnt_r == 4'h8) begin
                        cnt_r <= 4'h0;
                        if (lstate_r == L_PTR) begin
                            ptr_r    <= shreg_r;
                            lstate_r <= L_PACK;
                            sda_oe_r <= 1'b1;
                        end else if (lstate_r == L_WDATA) begin
                            lstate_r <= L_WACK;
                            sda_oe_r <= 1'b1;
                        end else if (shreg_r[7:1] == AACR_DEV_ADDR) begin
                            lstate_r <= L_AACK;
                            sda_oe_r <= 1'b1;
                            rw_r     <= shreg_r[0];
                            if (shreg_r[0]) begin
                                rd_addr_r <= ptr_r;
                                rd_tog_r  <= ~rd_tog_r;
                            end
                        end else begin
                            lstate_r <= L_IDLE;
                        end
                    end
                end
                L_AACK: begin
                    if (scl_fall && rw_r) begin
                        lstate_r <= L_RDATA;
                        shreg_r  <= rd_buf_r;
                        sda_oe_r <= ~rd_buf_r[7];
                        ptr_r    <= 8'(ptr_r + 8'h01);
                        cnt_r    <= 4'h0;
                    end else if (scl_fall) begin
                        lstate_r <= L_PTR;
                        sda_oe_r <= 1'b0;
                    end
                end
                L_PACK: begin
                    if (scl_fall) begin
                        lstate_r <= L_WDATA;
                        sda_oe_r <= 1'b0;
                    end
                end
                L_WACK: begin
                    // Commit only when the acknowledge clock ends
                    if (scl_fall) begin // see [RULE26]
                        wr_addr_r <= ptr_r;
                        wr_data_r <= shreg_r;
                        wr_tog_r  <= ~wr_tog_r;
                        ptr_r     <= 8'(ptr_r + 8'h01);
                        lstate_r  <= L_WDATA;
                        sda_oe_r  <= 1'b0;
                    end
                end
                L_RDATA: begin
                    if (scl_fall && cnt_r == 4'h7) begin
                        lstate_r  <= L_RACK;
                        sda_oe_r  <= 1'b0;
                        cnt_r     <= 4'h0;
                        rd_addr_r <= ptr_r;
                        rd_tog_r  <= ~rd_tog_r;
                    end else if (scl_fall) begin
                        shreg_r  <= {shreg_r[6:0], 1'b0};
                        sda_oe_r <= ~shreg_r[6];
                        cnt_r    <= 4'(cnt_r + 4'h1);
                    end
                end
                L_RACK: begin
                    if (scl_rise) begin
                        nack_r <= pin_s2_r[0];
                    end else if (scl_fall && nack_r) begin
                        lstate_r <= L_IDLE;
                    end else if (scl_fall) begin
                        lstate_r <= L_RDATA;
                        shreg_r  <= rd_buf_r;
                        sda_oe_r <= ~rd_buf_r[7];
                        ptr_r    <= 8'(ptr_r + 8'h01);
                    end
                end
            endcase
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_oe_r;

    a_commit_on_ack: assert property ( // see [RULE26]
        @(posedge link_clk_i) disable iff (!lrst_n_r)
        (lstate_r != L_WACK) |=> $stable(wr_tog_r))
        else $error("write committed outside data acknowledge");

    ////////////////////////////////////////////////////////////////////
    // System clock domain

    // Crossings in: toggles from the link, async fault levels
    always_ff @(posedge sys_clk_i) begin
        wt_s1_r  <= wr_tog_r;
        wt_s2_r  <= wt_s1_r;
        wt_s3_r  <= wt_s2_r;
        rt_s1_r  <= rd_tog_r;
        rt_s2_r  <= rt_s1_r;
        rt_s3_r  <= rt_s2_r;
        evt_s1_r <= {thermal_i, spk_l_oc_i, spk_r_oc_i,
                     hp_l_oc_i, hp_r_oc_i};
        evt_s2_r <= evt_s1_r;
    end

    // Reset has priority, so no write lands while it is low
    assign wr_fire = reset_n_i & (wt_s2_r ^ wt_s3_r); // see [RULE21]

    // Sticky over-current flags; a new event beats a clearing zero
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            flt_r <= AACR_RST_FAULT;
        end else if (wr_fire && wr_addr_r == AACR_ADDR_FAULT) begin
            flt_r <= (flt_r & wr_data_r[4:1]) | evt_s2_r[3:0]; // see [RULE18]
        end else begin
            flt_r <= flt_r | evt_s2_r[3:0]; // see [RULE19]
        end
    end

    // Soft shutdown and amplifier enables
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            power_r <= AACR_RST_POWER; // see [RULE13] [RULE22]
        end else if (wr_fire && wr_addr_r == AACR_ADDR_POWER) begin
            power_r <= wr_data_r[4:1]; // see [RULE15] [RULE25]
        end
    end

    // Mux mode and lock; the lock only ever rises until reset
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            mode_r <= AACR_RST_MODE; // see [RULE7]
            lock_r <= 1'b0; // see [RULE24]
        end else if (wr_fire && wr_addr_r == AACR_ADDR_MUX) begin
            mode_r <= wr_data_r[2:0]; // see [RULE6] [RULE25]
            if (!lock_r) begin // see [RULE23]
                lock_r <= wr_data_r[AACR_MUX_LOCK];
            end
        end
    end

    // Input volumes
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            mono_r <= AACR_RST_MONO;
            st1_r  <= AACR_RST_ST1;
            st2_r  <= AACR_RST_ST2;
        end else if (wr_fire) begin
            if (wr_addr_r == AACR_ADDR_MONO) begin
                mono_r <= wr_data_r[4:0];
            end
            if (wr_addr_r == AACR_ADDR_ST1) begin
                st1_r <= wr_data_r[4:0];
            end
            if (wr_addr_r == AACR_ADDR_ST2) begin
                st2_r <= wr_data_r[4:0];
            end
        end
    end

    // Headphone control; top three bits are not stored at all
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            vlim_r <= AACR_RST_VLIM; // see [RULE4]
            hpg_r  <= AACR_RST_HPG;
        end else if (wr_fire && wr_addr_r == AACR_ADDR_HP) begin // see [RULE1]
            hpg_r <= wr_data_r[1:0]; // see [RULE4]
            if (!lock_r) begin // see [RULE23]
                vlim_r <= wr_data_r[AACR_VLIM_LSB +: 3]; // see [RULE2]
            end
        end
    end

    // Read view; thermal is live, reserved and unmapped read zero
    always_comb begin
        unique case (rd_addr_r)
            AACR_ADDR_FAULT: rd_mux = {3'h0, flt_r, evt_s2_r[4]}; // see [RULE20]
            AACR_ADDR_POWER: rd_mux = {3'h0, power_r, 1'b0};
            AACR_ADDR_MUX:   rd_mux = {lock_r, 4'h0, mode_r};
            AACR_ADDR_MONO:  rd_mux = {3'h0, mono_r};
            AACR_ADDR_ST1:   rd_mux = {3'h0, st1_r};
            AACR_ADDR_ST2:   rd_mux = {3'h0, st2_r};
            AACR_ADDR_HP:    rd_mux = {3'h0, vlim_r, hpg_r};
            default:         rd_mux = 8'h00;
        endcase
    end

    // Read answer back to the link by toggle
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rd_data_r    <= 8'h00;
            rd_ack_tog_r <= 1'b0;
        end else if (rt_s2_r ^ rt_s3_r) begin
            rd_data_r    <= rd_mux;
            rd_ack_tog_r <= ~rd_ack_tog_r;
        end
    end

    // Output stage; shutdown gates every section off
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            bias_on_o       <= 1'b0;
            spk_on_o        <= 1'b0;
            hp_l_on_o       <= 1'b0;
            hp_r_on_o       <= 1'b0;
            left_mix_o      <= 10'h000;
            right_mix_o     <= 10'h000;
            mono_gain_o     <= AACR_RST_MONO;
            st1_gain_o      <= AACR_RST_ST1;
            st2_gain_o      <= AACR_RST_ST2;
            headphone_gain_select_sel_o   <= AACR_RST_HPG;
            headphone_gain_select_db_o    <= 5'sd0;
            hp_limit_code_o <= AACR_RST_VLIM;
            hp_limit_mv_o   <= 11'h000;
            limit_lock_o    <= 1'b0;
        end else begin
            bias_on_o <= ~power_r[3]; // see [RULE14]
            spk_on_o  <= ~power_r[3] & power_r[0]; // see [RULE16]
            hp_l_on_o <= ~power_r[3] & power_r[2]; // see [RULE17]
            hp_r_on_o <= ~power_r[3] & power_r[1]; // see [RULE17]
            // Coefficients weight signals already scaled by volume
            {left_mix_o, right_mix_o} <= mix_of(mode_r); // see [RULE8] [RULE9] [RULE10] [RULE12]
            mono_gain_o <= mono_r;
            st1_gain_o  <= st1_r;
            // Differential pairs both follow the first volume
            if (mode_r == AACR_STEREO_DIFF || mode_r == AACR_DIFF_MONO) begin
                st2_gain_o <= st1_r; // see [RULE11]
            end else begin
                st2_gain_o <= st2_r;
            end
            headphone_gain_select_sel_o   <= hpg_r;
            headphone_gain_select_db_o    <= aacr_gain_db(hpg_r); // see [RULE5]
            hp_limit_code_o <= vlim_r;
            hp_limit_mv_o   <= aacr_limit_mv(vlim_r); // see [RULE3]
            limit_lock_o    <= lock_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_locked_hp_write;
        lock_r && wr_fire && wr_addr_r == AACR_ADDR_HP;
    endsequence

    sequence s_hp_fault_kept;
        flt_r[1] && !(wr_fire && wr_addr_r == AACR_ADDR_FAULT
                      && !wr_data_r[2]);
    endsequence

    a_lock_freezes_limit: assert property ( // see [RULE23]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_locked_hp_write |=> $stable(vlim_r))
        else $error("limit changed while locked");

    a_lock_sticky: assert property ( // see [RULE24]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        lock_r |=> lock_r ##1 limit_lock_o)
        else $error("lock dropped without reset");

    a_spk_fault_latch: assert property ( // see [RULE18]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        evt_s2_r[3] ##1 !(wr_fire && wr_addr_r == AACR_ADDR_FAULT
                          && !wr_data_r[4]) |-> flt_r[3] [*2])
        else $error("speaker fault not latched");

    a_hp_fault_hold: assert property ( // see [RULE19]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_hp_fault_kept |=> flt_r[1])
        else $error("headphone fault lost without clear");

    a_shutdown_off: assert property ( // see [RULE14]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        power_r[3] |=> !bias_on_o && !spk_on_o && !hp_l_on_o && !hp_r_on_o)
        else $error("section active during shutdown");

    a_mute_mix: assert property ( // see [RULE10]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_r == AACR_MUTE |=> left_mix_o == 10'h000
                                && right_mix_o == 10'h000)
        else $error("mute mode passes audio");

    a_diff_volume: assert property ( // see [RULE11]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_r == AACR_STEREO_DIFF |=> st2_gain_o == $past(st1_r))
        else $error("differential right gain not first volume");

    a_reset_default: assert property ( // see [RULE22]
        @(posedge sys_clk_i)
        !reset_n_i |=> power_r == AACR_RST_POWER && mode_r == AACR_RST_MODE
                       && !lock_r && vlim_r == AACR_RST_VLIM)
        else $error("register not at default after reset");

endmodule

// >>> core/aacr_pkg.sv
/*
 * Constants and helpers for the audio amplifier control registers.
 * Imported by the control core, which keeps the register bank on the
 * system clock and the two-wire slave on the link clock, and by the bench.
 */
package aacr_pkg;

    // Register addresses on the two-wire bus
    localparam logic [7:0] AACR_ADDR_FAULT = 8'h01;
    localparam logic [7:0] AACR_ADDR_POWER = 8'h02;
    localparam logic [7:0] AACR_ADDR_MUX   = 8'h03;
    localparam logic [7:0] AACR_ADDR_MONO  = 8'h04;
    localparam logic [7:0] AACR_ADDR_ST1   = 8'h05;
    localparam logic [7:0] AACR_ADDR_ST2   = 8'h06;
    localparam logic [7:0] AACR_ADDR_HP    = 8'h07;

    // Slave address; the value is arbitrary
    localparam logic [6:0] AACR_DEV_ADDR = 7'h3A;

    // Values after reset
    localparam logic [3:0] AACR_RST_FAULT = 4'h0;
    localparam logic [3:0] AACR_RST_POWER = 4'h8;
    localparam logic [2:0] AACR_RST_MODE  = 3'h1;
    localparam logic [4:0] AACR_RST_MONO  = 5'h13;
    localparam logic [4:0] AACR_RST_ST1   = 5'h10;
    localparam logic [4:0] AACR_RST_ST2   = 5'h10;
    localparam logic [2:0] AACR_RST_VLIM  = 3'h0;
    localparam logic [1:0] AACR_RST_HPG   = 2'h0;

    // Field positions in the register bytes
    localparam int AACR_FLT_LSB  = 1;
    localparam int AACR_THERMAL  = 0;
    localparam int AACR_PWR_LSB  = 1;
    localparam int AACR_MUX_LOCK = 7;
    localparam int AACR_VLIM_LSB = 2;

    // Mux modes in code order
    typedef enum logic [2:0] {
        AACR_MONO_DIFF, AACR_STEREO1, AACR_STEREO2, AACR_STEREO_DIFF,
        AACR_DIFF_MONO, AACR_ST1_MONO, AACR_ST2_MONO, AACR_MUTE
    } aacr_mode_t;

    // Per-input mix coefficient
    localparam logic [1:0] AACR_MIX_OFF = 2'h0;
    localparam logic [1:0] AACR_MIX_ADD = 2'h1;
    localparam logic [1:0] AACR_MIX_SUB = 2'h3;

    // Headphone swing limit in millivolts, zero meaning unlimited
    function automatic logic [10:0] aacr_limit_mv(input logic [2:0] c);
        unique case (c)
            3'h0: aacr_limit_mv = 11'd0;
            3'h1: aacr_limit_mv = 11'd1130;
            3'h2: aacr_limit_mv = 11'd540;
            3'h3: aacr_limit_mv = 11'd380;
            3'h4: aacr_limit_mv = 11'd315;
            3'h5: aacr_limit_mv = 11'd253;
            3'h6: aacr_limit_mv = 11'd227;
            3'h7: aacr_limit_mv = 11'd196;
        endcase
    endfunction

    // Headphone gain in dB
    function automatic logic signed [4:0] aacr_gain_db(input logic [1:0] c);
        unique case (c)
            2'h0: aacr_gain_db = 5'sd6;
            2'h1: aacr_gain_db = 5'sd0;
            2'h2: aacr_gain_db = -5'sd6;
            2'h3: aacr_gain_db = -5'sd14;
        endcase
    endfunction

endpackage

// >>> bench/aacr_host.sv
/* Two-wire bus master standing in for the host processor.
   Assumes an SDA pull-up and a slave syncing SCL on its own clock. */
`timescale 1ns/1ps
module aacr_host (
    input  wire logic clk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    import aacr_pkg::*;
    logic sda_r;
    // Open drain: the pull-up wins unless a party pulls low
    assign sda_o = sda_r & ~sda_oe_i;
    // Idle bus: SCL stands high, SDA released
    initial begin
        scl_o = 1'b1;
        sda_r = 1'b1;
    end
    // Half bit of 1.6 us covers the slave's sync lag and read fetch
    task automatic half();
        repeat (40) @(posedge clk_i);
    endtask
    // SDA moves well after SCL falls, never beside it
    task automatic bitx(input logic b, output logic r);
        repeat (10) @(posedge clk_i);
        sda_r <= b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_o;
        scl_o <= 1'b0;
    endtask
    task automatic start();
        repeat (10) @(posedge clk_i);
        sda_r <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_r <= 1'b0;
        half();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        repeat (10) @(posedge clk_i);
        sda_r <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_r <= 1'b1;
        half();
    endtask
    // Byte MSB first, then the ninth acknowledge bit
    task automatic bytex(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, a);
        ack = ~a;
    endtask
    task automatic wr(input logic [7:0] a, d, output logic ok);
        logic [7:0] x;
        logic k0, k1, k2;
        start();
        bytex({AACR_DEV_ADDR, 1'b0}, x, k0);
        bytex(a, x, k1);
        bytex(d, x, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // Pointer write, repeated start, one byte ended by a NACK
    task automatic rd(input logic [7:0] a, output logic [7:0] q,
                      output logic ok);
        logic [7:0] x;
        logic k0, k1, k2, k3;
        start();
        bytex({AACR_DEV_ADDR, 1'b0}, x, k0);
        bytex(a, x, k1);
        start();
        bytex({AACR_DEV_ADDR, 1'b1}, x, k2);
        bytex(8'hFF, q, k3);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// >>> bench/testbench.sv
/* Self-checking bench for the audio amplifier control core.
   Assumes the package, the core and the host model compile first. */
`timescale 1ns/1ps
module testbench;
    import aacr_pkg::*;
    logic sys_clk, link_clk, reset_n, scl, sda, sda_oe, ok, bias, spk;
    logic hpl, hpr, lock;
    logic [4:0] oc, hdb, mg, g1, g2;
    logic [7:0] q;
    logic [9:0] lmix, rmix;
    logic [1:0] hsel;
    logic [2:0] lcode;
    logic [10:0] lmv;
    int fail_count, total_checks;
    // Clocks in a fixed 4:1 ratio, link edges midway between system rising edges
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        forever #80 link_clk = ~link_clk;
    end
    aacr_core i_dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .spk_l_oc_i(oc[4]), .spk_r_oc_i(oc[3]),
        .hp_l_oc_i(oc[2]), .hp_r_oc_i(oc[1]), .thermal_i(oc[0]),
        .bias_on_o(bias), .spk_on_o(spk), .hp_l_on_o(hpl), .hp_r_on_o(hpr),
        .left_mix_o(lmix), .right_mix_o(rmix), .mono_gain_o(mg),
        .st1_gain_o(g1), .st2_gain_o(g2), .headphone_gain_select_sel_o(hsel),
        .headphone_gain_select_db_o(hdb), .hp_limit_code_o(lcode),
        .hp_limit_mv_o(lmv), .limit_lock_o(lock));
    aacr_host i_host (.clk_i(sys_clk), .sda_oe_i(sda_oe), .scl_o(scl),
        .sda_o(sda));
    task automatic finish_test();
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [7:0] a, d);
        i_host.wr(a, d, ok);
        chk(ok, 1'b1);
    endtask
    task automatic r(input logic [7:0] a, e);
        i_host.rd(a, q, ok);
        chk({ok, q}, {1'b1, e});
    endtask
    task automatic rst();
        reset_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic t_def();
        chk({bias, spk, hpl, hpr, lock, lcode, hsel, lmv}, 0);
        chk({hdb, lmix, rmix}, {5'h06, 10'h040, 10'h010});
        chk({mg, g1, g2}, {5'h13, 5'h10, 5'h10});
        r(AACR_ADDR_MUX, 8'h01);
        r(AACR_ADDR_HP, 8'h00);
        $display("defaults done");
    endtask
    task automatic t_pwr();
        w(AACR_ADDR_POWER, 8'h0E);
        chk({bias, spk, hpl, hpr}, 4'hF);
        w(AACR_ADDR_POWER, 8'h1E);
        chk({bias, spk, hpl, hpr}, 4'h0);
        w(AACR_ADDR_POWER, 8'h04);
        chk({bias, spk, hpl, hpr}, 4'h9);
        $display("power done");
    endtask
    task automatic t_mux();
        logic [19:0] mx[8] = '{20'h40100, 20'h10010, 20'h01001, 20'h1C007,
                               20'h1DC77, 20'h14050, 20'h01405, 20'h00000};
        w(AACR_ADDR_ST2, 8'h05);
        for (int k = 0; k < 8; k++) begin
            w(AACR_ADDR_MUX, 8'(k));
            chk({lmix, rmix}, mx[k]);
            chk(g2, (k == 3 || k == 4) ? 5'h10 : 5'h05);
        end
        $display("mux done");
    endtask
    task automatic t_hp();
        logic [10:0] mv[4] = '{11'h13B, 11'h0FD, 11'h0E3, 11'h0C4};
        logic [4:0] db[4] = '{5'h06, 5'h00, 5'h1A, 5'h12};
        for (int k = 0; k < 4; k++) begin
            w(AACR_ADDR_HP, {3'h7, 3'(k + 4), 2'(k)});
            chk({hdb, hsel, lcode}, {db[k], 2'(k), 3'(k + 4)});
            chk(lmv, mv[k]);
        end
        r(AACR_ADDR_HP, 8'h1F);
        $display("headphone done");
    endtask
    task automatic t_lock();
        w(AACR_ADDR_MUX, 8'h81);
        w(AACR_ADDR_HP, 8'h00);
        chk({lock, lcode, hsel}, 6'h3C);
        w(AACR_ADDR_MUX, 8'h02);
        chk({lock, lmix}, {1'b1, 10'h004});
        r(AACR_ADDR_MUX, 8'h82);
        $display("lock done");
    endtask
    task automatic t_flt();
        oc <= 5'h1F;
        repeat (10) @(posedge sys_clk);
        oc <= 5'h01;
        repeat (10) @(posedge sys_clk);
        r(AACR_ADDR_FAULT, 8'h1F);
        oc <= 5'h00;
        w(AACR_ADDR_FAULT, 8'hFF);
        r(AACR_ADDR_FAULT, 8'h1E);
        w(AACR_ADDR_FAULT, 8'h00);
        r(AACR_ADDR_FAULT, 8'h00);
        $display("fault done");
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        oc = 5'h00;
        rst();
        t_def();
        t_pwr();
        t_mux();
        t_hp();
        t_lock();
        t_flt();
        rst();
        chk({lock, lcode, lmix}, 13'h040);
        finish_test();
    end
endmodule
